/* File: sfdp_and_unique_id_readout_test.sv */
// Self-checking bench for the parameter and identifier read-out
`timescale 1ns/1ns
module sfdp_and_unique_id_readout_test import sfdp_pkg::*;;
   // Arbitrary neutral maker code
   localparam logic [7:0] MAKER = 8'h3c;
   localparam logic [127:0] UID_A = 128'h0123456789abcdef_fedcba9876543210;
   localparam logic [127:0] UID_B = 128'h5a5aa5a5_0f0ff0f0_c3c33c3c_96966969;
   localparam logic [191:0] EXP_HDR = {96'h53464450_000101ff_00000109,
      32'h300000ff, MAKER, 56'h00010360_0000ff};

   logic mclk, arst_n, sclk, cs_n, si, so, so_oe, rd_act, uid_rd;
   logic [127:0] uid;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;

   sfdp_and_unique_id_readout #(.MAKER_ID(MAKER), .FIFO_DEPTH(8)) u_dut (
      .mclk_i(mclk), .arst_n_i(arst_n), .sclk_i(sclk), .cs_n_i(cs_n),
      .si_i(si), .uid_i(uid), .so_o(so), .so_oe_o(so_oe),
      .read_active_o(rd_act), .unique_id_read_o(uid_rd));

   spi_host_model u_host (.mclk_i(mclk), .so_i(so), .so_oe_i(so_oe),
      .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [191:0] seen,
                        input logic [191:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("ERROR timeout after %0d cycles", cycles);
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_header();
      fork
         u_host.xfer(OP_PARAM_READ, 24'h000000, 24, 0, 0, 1'b1);
         begin
            #30000;
            check("read_active", rd_act, 1'b1);
            check("uid_flag_param", uid_rd, 1'b0);
         end
      join
      check("header", u_host.rx, EXP_HDR);
      check("header_oe", u_host.oe_err, 0);
   endtask

   task automatic t_table();
      u_host.xfer(OP_PARAM_READ, 24'h00002e, 18, 0, 0, 1'b1);
      check("basic", u_host.rx,
         144'hffffe520f1ffffff7f0044eb086bffffffff);
   endtask

   task automatic t_uid();
      fork
         u_host.xfer(OP_PARAM_READ, 24'h000194, 18, 0, 0, 1'b1);
         begin
            #30000;
            check("uid_flag", uid_rd, 1'b1);
         end
      join
      check("uid", u_host.rx, {UID_A, 16'hffff});
      check("uid_oe", u_host.oe_err, 0);
   endtask

   task automatic t_bad_op();
      u_host.xfer(8'h03, 24'h000000, 4, 0, 0, 1'b0);
      check("bad_op_oe", u_host.oe_err, 0);
      check("bad_op_data", u_host.rx, 32'hffffffff);
   endtask

   task automatic t_abort();
      u_host.xfer(OP_PARAM_READ, 24'h000000, 1, 3, 0, 1'b1);
      check("partial", u_host.rx, {8'h53, 3'b010});
      u_host.xfer(OP_PARAM_READ, 24'h000004, 4, 0, 0, 1'b1);
      check("after_abort", u_host.rx, 32'h000101ff);
   endtask

   task automatic t_stall();
      u_host.xfer(OP_PARAM_READ, 24'h000030, 12, 0, 2, 1'b1);
      check("stall", u_host.rx, 96'he520f1ffffff7f0044eb086b);
      check("stall_oe", u_host.oe_err, 0);
   endtask

   task automatic t_reset_mid();
      fork
         u_host.xfer(OP_PARAM_READ, 24'h000000, 8, 0, 0, 1'b1);
         begin
            #20000;
            @(negedge mclk);
            arst_n = 1'b0;
            @(negedge mclk);
            check("rst_oe", so_oe, 1'b0);
            check("rst_so", so, 1'b1);
            check("rst_active", rd_act, 1'b0);
            check("rst_uid_flag", uid_rd, 1'b0);
         end
      join
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      repeat (3) @(negedge mclk);
      u_host.xfer(OP_PARAM_READ, 24'h000194, 16, 0, 0, 1'b1);
      check("uid_recaptured", u_host.rx, UID_B);
   endtask

   initial begin
      arst_n = 1'b0;
      uid = UID_A;
      repeat (3) @(negedge mclk);
      arst_n = 1'b1;
      repeat (2) @(negedge mclk);
      // Fuse value moves after capture; reads must keep the first one
      uid = UID_B;
      t_header();
      t_table();
      t_uid();
      t_bad_op();
      t_abort();
      t_stall();
      t_reset_mid();
      end_sim();
   end
endmodule // sfdp_and_unique_id_readout_test

/* File: sfdp_pkg.sv */
// Constants, tables and types for the parameter and identifier read-out
// ---------------------------------------------------------------------
// What this block does
// - A fixed 128-bit per-part identifier is held read-only; no command alters it.
// - Opcode 5AH, address 000194H, one dummy byte, then 16 identifier bytes, then FFH until deselect.
// - Bytes 00H-03H give 53H 46H 44H 50H; 04H gives 00H; 05H gives 01H.
// - Byte 06H gives 01H: two parameter headers follow the signature.
// - Unused header bytes 07H, 0FH, 17H always give FFH.
// - First header: ID 00H, revision 1.0, length 09H, pointer 000030H.
// - Second header: revision 1.0, length 03H, pointer 000060H.
// - Byte 10H gives the maker code, not a standard table ID.
// - Byte 30H gives E5H and byte 31H gives 4KB erase opcode 20H.
// - Byte 32H gives F1H and byte 33H gives FFH.
// - Byte 38H gives 44H and byte 39H gives EBH.
// - Byte 3AH gives 08H for the 1-1-4 read timing.
// - Byte 3BH gives 6BH, the 1-1-4 fast read opcode.
// - Parameter space is read with opcode 5AH only.
// ---------------------------------------------------------------------
package sfdp_pkg;

   // ---------------------------------------------------------------
   // Serial command framing
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_PARAM_READ = 8'h5a;
   localparam logic [5:0] CMD_LAST = 6'h07;
   localparam logic [5:0] ADDR_LAST = 6'h1f;
   localparam logic [5:0] DUMMY_LAST = 6'h27;
   localparam logic [23:0] UID_ADDR = 24'h000194;
   localparam logic [23:0] UID_LEN = 24'h000010;

   // ---------------------------------------------------------------
   // Parameter space layout and contents (byte 0 in the low bits)
   // ---------------------------------------------------------------
   localparam logic [23:0] HDR_LEN = 24'h000018;
   localparam logic [23:0] MAKER_ID_ADDR = 24'h000010;
   localparam logic [191:0] HDR_BYTES =
      192'hff000060_03010000_ff000030_09010000_ff010100_50444653;
   localparam logic [23:0] BASIC_BASE = 24'h000030;
   localparam logic [23:0] BASIC_LEN = 24'h00000c;
   localparam logic [95:0] BASIC_BYTES = 96'h6b08eb44_007fffff_fff120e5;
   localparam logic [7:0] BLANK_BYTE = 8'hff;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [127:0] UID_RESET = 128'h0;
   localparam logic [7:0] BYTE_RESET = 8'hff;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic si;
   } spi_pins_s;

   localparam spi_pins_s PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
   } link_state_e;

endpackage

/* File: sfdp_uid_readout.sv */
// Read-out engine for discoverable parameters and the unique identifier
`timescale 1ns/1ns

// ---------------------------------------------------------------------
// Byte FIFO between table fetch and serial shifter
// ---------------------------------------------------------------------
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,                 // System clock
   input wire logic arst_n_i,              // Async reset, active low
   input wire logic flush_i,               // Empties the FIFO
   input wire logic in_valid_i,            // Write request
   output logic in_ready_o,                // Room for a word
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic out_valid_o,               // Word available
   input wire logic out_ready_i,           // Read request
   output logic [WIDTH-1:0] out_data_o     // Head word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire logic do_wr = in_valid_i & in_ready_o;
   wire logic do_rd = out_valid_o & out_ready_i;
   wire logic [AW-1:0] wr_nxt = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
   wire logic [AW-1:0] rd_nxt = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;

   assign in_ready_o = (cnt_q != DEPTH_CNT) & ~flush_i;
   assign out_valid_o = (cnt_q != '0) & ~flush_i;
   assign out_data_o = mem_q[rd_q];

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_wr) begin
            wr_q <= wr_nxt;
         end
         if (do_rd) begin
            rd_q <= rd_nxt;
         end
         cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule // byte_fifo

// ---------------------------------------------------------------------
// Serial flash read-out top
// ---------------------------------------------------------------------
module sfdp_and_unique_id_readout
   import sfdp_pkg::*;
#(
   // Arbitrary neutral maker code
   parameter logic [7:0] MAKER_ID = 8'ha7,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk_i,           // 20 MHz system clock
   input wire logic arst_n_i,         // Async reset, active low
   input wire logic sclk_i,           // Serial clock pin
   input wire logic cs_n_i,           // Chip select pin, active low
   input wire logic si_i,             // Serial data in pin
   input wire logic [127:0] uid_i,    // Factory identifier fuses
   output logic so_o,                 // Serial data out
   output logic so_oe_o,              // Serial data out drive enable
   output logic read_active_o,        // Data phase in progress
   output logic unique_id_read_o      // Current read is the identifier
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ---------------------------------------------------------------
   spi_pins_s pin_s1_q;
   spi_pins_s pin_s2_q;
   logic sclk_prev_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_q <= PINS_IDLE;
         pin_s2_q <= PINS_IDLE;
         sclk_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= '{sclk: sclk_i, cs_n: cs_n_i, si: si_i};
         pin_s2_q <= pin_s1_q;
         sclk_prev_q <= pin_s2_q.sclk;
      end
   end

   wire logic rise = pin_s2_q.sclk & ~sclk_prev_q;
   wire logic fall = ~pin_s2_q.sclk & sclk_prev_q;
   wire logic sel = ~pin_s2_q.cs_n;
   wire logic si_s = pin_s2_q.si;

   // ---------------------------------------------------------------
   // Identifier capture, once after reset release
   // ---------------------------------------------------------------
   logic [127:0] uid_q;
   logic uid_done_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         uid_q <= UID_RESET;
         uid_done_q <= 1'b0;
      end else if (!uid_done_q) begin
         uid_q <= uid_i;
         uid_done_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Command, address and dummy phases
   // ---------------------------------------------------------------
   link_state_e state_q, state_d;
   logic [5:0] cnt_q;
   logic [23:0] in_sh_q;
   wire logic [23:0] in_sh_nxt = {in_sh_q[22:0], si_s};
   wire logic cmd_ok = (in_sh_nxt[7:0] == OP_PARAM_READ);
   wire logic addr_done = rise & (state_q == ST_ADDR) & (cnt_q == ADDR_LAST);
   wire logic in_frame = (state_q == ST_CMD) | (state_q == ST_ADDR) |
                         (state_q == ST_DUMMY);

   always_comb begin
      state_d = state_q;
      if (!sel) begin
         state_d = ST_IDLE;
      end else if (rise) begin
         unique case (state_q)
            ST_IDLE: state_d = ST_CMD;
            ST_CMD: begin
               if (cnt_q == CMD_LAST) begin
                  state_d = cmd_ok ? ST_ADDR : ST_IGNORE;
               end
            end
            ST_ADDR: begin
               if (cnt_q == ADDR_LAST) begin
                  state_d = ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               if (cnt_q == DUMMY_LAST) begin
                  state_d = ST_DATA;
               end
            end
            ST_DATA: state_d = ST_DATA;
            ST_IGNORE: state_d = ST_IGNORE;
         endcase
      end else if (state_q == ST_IDLE) begin
         state_d = ST_CMD;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         in_sh_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_d == ST_IDLE) begin
            cnt_q <= '0;
         end else if (rise & in_frame) begin
            cnt_q <= cnt_q + 6'h01;
            in_sh_q <= in_sh_nxt;
         end
      end
   end

   // ---------------------------------------------------------------
   // Table fetch into the FIFO
   // ---------------------------------------------------------------
   function automatic logic [7:0] param_byte(input logic [23:0] a);
      logic [23:0] off;
      off = a - BASIC_BASE;
      if (a == MAKER_ID_ADDR) begin
         param_byte = MAKER_ID;
      end else if (a < HDR_LEN) begin
         param_byte = 8'(HDR_BYTES >> {a[4:0], 3'b000});
      end else if (a >= BASIC_BASE && off < BASIC_LEN) begin
         param_byte = 8'(BASIC_BYTES >> {off[3:0], 3'b000});
      end else begin
         param_byte = BLANK_BYTE;
      end
   endfunction

   logic [23:0] addr_q;
   logic fetch_q;
   logic uid_sel_q;
   wire logic [23:0] uid_off = addr_q - UID_ADDR;
   wire logic [7:0] uid_byte = (uid_off < UID_LEN) ?
      8'(uid_q >> {~uid_off[3:0], 3'b000}) : BLANK_BYTE;
   wire logic [7:0] push_data = uid_sel_q ? uid_byte : param_byte(addr_q);
   wire logic flush = (state_q == ST_IDLE) | (state_q == ST_IGNORE);
   logic push_ready;
   wire logic push = fetch_q & push_ready;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_q <= '0;
         fetch_q <= 1'b0;
         uid_sel_q <= 1'b0;
      end else if (flush) begin
         fetch_q <= 1'b0;
         uid_sel_q <= 1'b0;
      end else if (addr_done) begin
         addr_q <= in_sh_nxt;
         fetch_q <= 1'b1;
         uid_sel_q <= (in_sh_nxt == UID_ADDR);
      end else if (push) begin
         addr_q <= addr_q + 24'h000001;
      end
   end

   logic pop_valid;
   logic [7:0] pop_data;
   logic [2:0] bit_q;
   wire logic shift_ev = fall & (state_q == ST_DATA);
   wire logic pop = shift_ev & (bit_q == 3'h0);

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .flush_i(flush),
      .in_valid_i(fetch_q),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(pop_valid),
      .out_ready_i(pop),
      .out_data_o(pop_data)
   );

   // ---------------------------------------------------------------
   // Output shifter, one bit per serial clock falling edge
   // ---------------------------------------------------------------
   logic [7:0] out_sh_q;
   logic so_q;
   logic so_oe_q;
   wire logic [7:0] next_byte = pop_valid ? pop_data : BLANK_BYTE;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_sh_q <= BYTE_RESET;
         bit_q <= '0;
         so_q <= 1'b1;
         so_oe_q <= 1'b0;
      end else begin
         so_oe_q <= (state_d == ST_DATA);
         if (state_q != ST_DATA) begin
            bit_q <= '0;
            so_q <= 1'b1;
         end else if (pop) begin
            so_q <= next_byte[7];
            out_sh_q <= {next_byte[6:0], 1'b1};
            bit_q <= 3'h1;
         end else if (shift_ev) begin
            so_q <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b1};
            bit_q <= bit_q + 3'h1;
         end
      end
   end

   assign so_o = so_q;
   assign so_oe_o = so_oe_q;
   assign read_active_o = (state_q == ST_DATA);
   assign unique_id_read_o = uid_sel_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   property p_uid_frozen;
      uid_done_q |=> $stable(uid_q);
   endproperty
   a_uid_frozen: assert property (p_uid_frozen)
      else $error("identifier changed after capture");

   property p_uid_first;
      push && uid_sel_q && addr_q == UID_ADDR |-> push_data == uid_q[127:120];
   endproperty
   a_uid_first: assert property (p_uid_first)
      else $error("identifier does not start with its top byte");

   property p_sig;
      push && !uid_sel_q && addr_q == 24'h000003 |-> push_data == 8'h50;
   endproperty
   a_sig: assert property (p_sig)
      else $error("signature byte 3 wrong");

   property p_hdr_count;
      push && !uid_sel_q && addr_q == 24'h000006 |-> push_data == 8'h01;
   endproperty
   a_hdr_count: assert property (p_hdr_count)
      else $error("header count wrong");

   property p_unused;
      push && !uid_sel_q && (addr_q == 24'h000007 || addr_q == 24'h00000f ||
         addr_q == 24'h000017) |-> push_data == 8'hff;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused header byte not FFH");

   property p_ptr0;
      push && !uid_sel_q && addr_q == 24'h00000c |-> push_data == 8'h30;
   endproperty
   a_ptr0: assert property (p_ptr0)
      else $error("first table pointer wrong");

   property p_ptr1;
      push && !uid_sel_q && addr_q == 24'h000014 |-> push_data == 8'h60;
   endproperty
   a_ptr1: assert property (p_ptr1)
      else $error("second table pointer wrong");

   property p_maker;
      push && !uid_sel_q && addr_q == 24'h000010 |-> push_data == MAKER_ID;
   endproperty
   a_maker: assert property (p_maker)
      else $error("maker code byte wrong");

   property p_basic;
      push && !uid_sel_q && addr_q == 24'h000030 |-> push_data == 8'he5;
   endproperty
   a_basic: assert property (p_basic)
      else $error("basic table byte 30H wrong");

   property p_modes;
      push && !uid_sel_q && addr_q == 24'h000032 |-> push_data == 8'hf1;
   endproperty
   a_modes: assert property (p_modes)
      else $error("basic table byte 32H wrong");

   property p_quad_io;
      push && !uid_sel_q && addr_q == 24'h000038 |-> push_data == 8'h44;
   endproperty
   a_quad_io: assert property (p_quad_io)
      else $error("basic table byte 38H wrong");

   property p_quad_out;
      push && !uid_sel_q && addr_q == 24'h00003a |-> push_data == 8'h08;
   endproperty
   a_quad_out: assert property (p_quad_out)
      else $error("basic table byte 3AH wrong");

   property p_quad_op;
      push && !uid_sel_q && addr_q == 24'h00003b |-> push_data == 8'h6b;
   endproperty
   a_quad_op: assert property (p_quad_op)
      else $error("basic table byte 3BH wrong");

   property p_opcode;
      rise && sel && state_q == ST_CMD && cnt_q == CMD_LAST && !cmd_ok
         |=> state_q == ST_IGNORE ##1 !so_oe_o;
   endproperty
   a_opcode: assert property (p_opcode)
      else $error("foreign opcode not ignored");

   property p_advance;
      push && !addr_done && !flush |=> addr_q == $past(addr_q) + 24'h000001;
   endproperty
   a_advance: assert property (p_advance)
      else $error("address did not advance");

   property p_msb_first;
      pop && pop_valid |=> so_o == $past(pop_data[7]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("byte not sent MSB first");

   property p_blank;
      push && !uid_sel_q && addr_q == 24'h00002e |-> push_data == 8'hff;
   endproperty
   a_blank: assert property (p_blank)
      else $error("undefined address not FFH");

   c_uid_read: cover property (pop && uid_sel_q);
   c_param_read: cover property (pop && !uid_sel_q);
   c_ignored: cover property (state_q == ST_IGNORE);
   c_fifo_full: cover property (fetch_q && !push_ready && !flush);

endmodule // sfdp_and_unique_id_readout

/* File: spi_host_model.sv */
// Host-side serial bus model issuing parameter and identifier reads
`timescale 1ns/1ns
module spi_host_model
   import sfdp_pkg::*;
(
   input wire logic mclk_i,  // System clock, used only for phase
   input wire logic so_i,    // Device serial data out
   input wire logic so_oe_i, // Device drive enable
   output logic sclk_o,      // Serial clock, mode 0, still between frames
   output logic cs_n_o,      // Chip select, active low
   output logic si_o         // Serial data to the device
);
   localparam int HALF = 200;

   logic [191:0] rx;
   int oe_err;

   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      rx = '0;
      oe_err = 0;
   end

   // ---------------------------------------------------------------
   // One frame: opcode, address, dummy, then data bytes and extra bits
   // ---------------------------------------------------------------
   task automatic xfer(input logic [7:0] op, input logic [23:0] addr,
                       input int nbytes, input int extra, input int stall,
                       input bit want);
      logic [39:0] hdr;
      hdr = {op, addr, 8'h00};
      rx = '0;
      oe_err = 0;
      @(negedge mclk_i);
      cs_n_o = 1'b0;
      for (int i = 39; i >= 0; i--) begin
         si_o = hdr[i];
         #HALF;
         sclk_o = 1'b1;
         if (so_oe_i !== 1'b0) oe_err++;
         #HALF;
         sclk_o = 1'b0;
      end
      for (int b = 0; b < nbytes * 8 + extra; b++) begin
         // Clock held low mid-read so the prefetch buffer fills up
         if (stall > 0 && b == stall * 8) #(20 * HALF);
         si_o = ~si_o;
         #HALF;
         sclk_o = 1'b1;
         #HALF;
         // Bit launched on the previous fall is taken at this fall
         rx = {rx[190:0], so_i};
         if (so_oe_i !== want) oe_err++;
         sclk_o = 1'b0;
      end
      #HALF;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #(HALF + 100);
   endtask
endmodule // spi_host_model
